// ==== rtl/smer_regs.sv ====
// management-mode enhancement register bank
// assumes thread state inputs arrive from other clock domains
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "smer_consts.svh"

module smer_regs #(
   parameter int  NUM_THREADS    = 12,
   parameter bit  GUARD_SUPPORT  = 1'b1,
   parameter bit  LONG_SUPPORT   = 1'b1
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // register port
   input  wire logic [11:0]            addr,
   input  wire logic [63:0]            wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [63:0]            rdata,
   // processor status
   input  wire logic                   in_smm,
   input  wire logic [NUM_THREADS-1:0] long_op_busy,
   input  wire logic [NUM_THREADS-1:0] thread_blocked,
   input  wire logic [NUM_THREADS-1:0] smm_fetch_outside,
   // events
   output logic                        machine_check_event,
   output logic                        irq
);

   // ==========================================================
   // input synchronisers
   logic [NUM_THREADS-1:0] long_s1, long_s2, blk_s1, blk_s2, out_s1, out_s2;
   logic                   smm_s1, smm_s2;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         long_s1 <= '0;
         long_s2 <= '0;
         blk_s1  <= '1;
         blk_s2  <= '1;
         out_s1  <= '0;
         out_s2  <= '0;
         smm_s1  <= 1'b0;
         smm_s2  <= 1'b0;
      end else begin
         long_s1 <= long_op_busy;
         long_s2 <= long_s1;
         blk_s1  <= thread_blocked;
         blk_s2  <= blk_s1;
         out_s1  <= smm_fetch_outside;
         out_s2  <= out_s1;
         smm_s1  <= in_smm;
         smm_s2  <= smm_s1;
      end
   end

   // ==========================================================
   // access decode
   logic hit_cap, hit_ctrl, hit_del, hit_blk, hit_stat, hit_mask;
   logic cap_ok, ctrl_ok, del_ok, blk_ok;

   assign hit_cap  = addr == `SMER_ADDR_CAP;
   assign hit_ctrl = addr == `SMER_ADDR_CTRL;
   assign hit_del  = addr == `SMER_ADDR_DELAYED;
   assign hit_blk  = addr == `SMER_ADDR_BLOCKED;
   assign hit_stat = addr == `SMER_ADDR_IRQ_STAT;
   assign hit_mask = addr == `SMER_ADDR_IRQ_MASK;
   assign cap_ok   = hit_cap && smm_s2;
   assign ctrl_ok  = hit_ctrl && smm_s2 && GUARD_SUPPORT;
   assign del_ok   = hit_del && smm_s2 && LONG_SUPPORT;
   assign blk_ok   = hit_blk && smm_s2;

   // ==========================================================
   // feature control
   smer_pkg::smer_ctrl_t ctrl;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= '0;
      end else if (wr && ctrl_ok && !ctrl.lock) begin
         ctrl.lock         <= wdata[`SMER_CTRL_LOCK_BIT];
         ctrl.guard_enable <= wdata[`SMER_CTRL_EN_BIT];
      end
   end

   // ==========================================================
   // per-thread vectors
   logic [63:0] delayed, blocked;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delayed <= `SMER_DELAYED_RESET;
         blocked <= `SMER_BLOCKED_RESET;
      end else begin
         delayed <= '0;
         blocked <= '0;
         delayed[NUM_THREADS-1:0] <= long_s2;
         blocked[NUM_THREADS-1:0] <= blk_s2;
      end
   end

   // ==========================================================
   // code guard check
   logic violation;

   assign violation = ctrl.guard_enable && (|out_s2);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         machine_check_event <= 1'b0;
      end else begin
         machine_check_event <= violation;
      end
   end

   // ==========================================================
   // interrupt status and mask
   smer_pkg::smer_irq_t stat, mask, ev;
   logic denied;

   assign denied = (wr || rd) &&
                   ((hit_cap && !cap_ok) || (hit_ctrl && !ctrl_ok) ||
                    (hit_del && !del_ok) || (hit_blk && !blk_ok) ||
                    (wr && (hit_cap || hit_del || hit_blk)));
   assign ev.guard_violation = violation;
   assign ev.denied_access   = denied;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat <= '0;
      end else if (rd && hit_stat) begin
         stat <= ev;
      end else begin
         stat <= stat | ev;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask <= '0;
      end else if (wr && hit_mask) begin
         mask <= wdata[1:0];
      end
   end

   assign irq = |(stat & mask);

   // ==========================================================
   // read data
   logic [63:0] cap_val;

   always_comb begin
      cap_val = '0;
      cap_val[`SMER_CAP_GUARD_BIT] = GUARD_SUPPORT;
      cap_val[`SMER_CAP_LONG_BIT]  = LONG_SUPPORT;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= '0;
         if (cap_ok) rdata <= cap_val;
         if (ctrl_ok) begin
            rdata[`SMER_CTRL_LOCK_BIT] <= ctrl.lock;
            rdata[`SMER_CTRL_EN_BIT]   <= ctrl.guard_enable;
         end
         if (del_ok) rdata <= delayed;
         if (blk_ok) rdata <= blocked;
         if (hit_stat) rdata <= {62'h0, stat};
         if (hit_mask) rdata <= {62'h0, mask};
      end else begin
         rdata <= '0;
      end
   end

endmodule // smer_regs

// ==== include/smer_consts.svh ====
// constants for the management-mode enhancement register bank
// assumes a plain register port with 64-bit data and 12-bit index address
`ifndef SMER_CONSTS_SVH
`define SMER_CONSTS_SVH

// ==========================================================
// register indexes
`define SMER_ADDR_CAP      12'h17d
`define SMER_ADDR_CTRL     12'h4e0
`define SMER_ADDR_DELAYED  12'h4e2
`define SMER_ADDR_BLOCKED  12'h4e3
`define SMER_ADDR_IRQ_STAT 12'h4f0
`define SMER_ADDR_IRQ_MASK 12'h4f1

// ==========================================================
// field positions
`define SMER_CAP_GUARD_BIT 58
`define SMER_CAP_LONG_BIT  59
`define SMER_CTRL_LOCK_BIT 0
`define SMER_CTRL_EN_BIT   2

// ==========================================================
// reset values
`define SMER_BLOCKED_RESET 64'h0000_0000_0000_0fff
`define SMER_DELAYED_RESET 64'h0000_0000_0000_0000

`endif

// ==== include/smer_pkg.sv ====
// types for the management-mode enhancement register bank
// assumes nothing beyond the constants header
package smer_pkg;

   // ==========================================================
   // feature control contents
   typedef struct packed {
      logic guard_enable;
      logic lock;
   } smer_ctrl_t;

   // ==========================================================
   // interrupt status layout
   typedef struct packed {
      logic denied_access;
      logic guard_violation;
   } smer_irq_t;

endpackage

// ==== verification/smer_checker.sv ====
// assertions on the bank's register port and events
// assumes it is bound into smer_regs
`timescale 1ns/1ns
module smer_checker #(parameter int NUM_THREADS = 12) (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // port, status, events
   input wire logic [11:0]            addr,
   input wire logic                   rd,
   input wire logic [63:0]            rdata,
   input wire logic                   in_smm,
   input wire logic [NUM_THREADS-1:0] long_op_busy,
   input wire logic [NUM_THREADS-1:0] thread_blocked,
   input wire logic [NUM_THREADS-1:0] smm_fetch_outside,
   input wire logic                   machine_check_event,
   input wire logic                   irq
);
   // ===
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_in; in_smm[*3]; endsequence
   sequence s_out; (!in_smm)[*3]; endsequence
   AST_IDLE: assert property (!$past(rd) |-> rdata == 64'h0)
      else $error("read data without a read");
   AST_CAP: assert property (s_in ##0 (rd && addr == 12'h17d)
      |=> rdata == 64'h0c00_0000_0000_0000) else $error("capability bits");
   AST_DENY: assert property (s_out ##0 (rd && addr[11:4] != 8'h4f)
      |=> rdata == 64'h0) else $error("read outside mode not refused");
   AST_MCE: assert property (machine_check_event
      |-> $past(smm_fetch_outside, 3) != 0) else $error("event without cause");
   AST_BLK: assert property (s_in ##0 ($stable(thread_blocked) && in_smm)[*5]
      ##0 (rd && addr == 12'h4e3) |=> rdata[NUM_THREADS-1:0] ==
      $past(thread_blocked)) else $error("blocked vector");
   AST_DLY: assert property (s_in ##0 ($stable(long_op_busy) && in_smm)[*5]
      ##0 (rd && addr == 12'h4e2) |=> rdata[NUM_THREADS-1:0] ==
      $past(long_op_busy)) else $error("delayed vector");
   AST_RESV: assert property ((rd && addr[11:1] == 11'h271)
      |=> rdata[63:NUM_THREADS] == 0) else $error("reserved bits set");
   AST_IRQ: assert property ((rd && addr == 12'h4f0 && !machine_check_event)
      ##1 !machine_check_event |-> !irq) else $error("irq after clear");
endmodule // smer_checker
bind smer_regs smer_checker #(.NUM_THREADS(NUM_THREADS)) i_smer_checker (
   .clk(clk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
   .in_smm(in_smm), .long_op_busy(long_op_busy),
   .thread_blocked(thread_blocked), .smm_fetch_outside(smm_fetch_outside),
   .machine_check_event(machine_check_event), .irq(irq));

// ==== verification/smer_regs_bench.sv ====
// register-level tests of the enhancement bank
// assumes the checker is bound in and default parameters
`timescale 1ns/1ns
module smer_regs_bench;
   // ===
   logic        clk = 0, rst = 1, wr = 0, rd = 0, in_smm = 0;
   logic [11:0] addr = 0, long_op_busy = 0, smm_fetch_outside = 0;
   logic [11:0] thread_blocked = 12'hfff;
   logic [63:0] wdata = 0, rdata;
   logic        machine_check_event, irq;
   int          errors = 0, tests_run = 0, cyc = 0;
   smer_regs i_smer_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .in_smm(in_smm),
      .long_op_busy(long_op_busy), .thread_blocked(thread_blocked),
      .smm_fetch_outside(smm_fetch_outside),
      .machine_check_event(machine_check_event), .irq(irq));
   initial forever #20 clk = ~clk;
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [11:0] a, input logic [63:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [11:0] a, input logic [63:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_reg(12'h17d, 64'h0);
      rd_reg(12'h4e2, 64'h0);
      rd_reg(12'h4e3, 64'h0);
      rd_reg(12'h4f0, 64'h2);
      rd_reg(12'h123, 64'h0);
      $display("test 1 done");
      @(posedge clk) in_smm <= 1'b1;
      w(3);
      rd_reg(12'h17d, 64'h0c00_0000_0000_0000);
      rd_reg(12'h4e3, 64'hfff);
      @(posedge clk) thread_blocked <= 12'h005;
      long_op_busy <= 12'h801;
      w(6);
      rd_reg(12'h4e3, 64'h005);
      rd_reg(12'h4e2, 64'h801);
      @(posedge clk) long_op_busy <= 12'h000;
      w(6);
      rd_reg(12'h4e2, 64'h0);
      $display("test 2 done");
      wr_reg(12'h4f1, 64'h1);
      @(posedge clk) smm_fetch_outside <= 12'h008;
      w(6);
      chk(machine_check_event, 64'h0);
      wr_reg(12'h4e0, 64'h4);
      w(2);
      chk(machine_check_event, 64'h1);
      chk(irq, 64'h1);
      @(posedge clk) smm_fetch_outside <= 12'h000;
      w(6);
      rd_reg(12'h4f0, 64'h1);
      chk(irq, 64'h0);
      $display("test 3 done");
      wr_reg(12'h4e0, 64'h5);
      wr_reg(12'h4e0, 64'h0);
      wr_reg(12'h17d, 64'h0);
      rd_reg(12'h4e0, 64'h5);
      rd_reg(12'h4f0, 64'h2);
      rd_reg(12'h17d, 64'h0c00_0000_0000_0000);
      $display("test 4 done");
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      w(3);
      rd_reg(12'h4e0, 64'h0);
      wr_reg(12'h4e0, 64'h4);
      rd_reg(12'h4e0, 64'h4);
      $display("test 5 done");
      summarize();
   end
endmodule // smer_regs_bench
